// File: rtl/flash_host_pkg.sv
package flash_host_pkg;

	// Clock and flash pin timing
	localparam int CLK_NS     = 20;
	localparam int T_ACC_NS   = 55;
	localparam int T_WP_NS    = 35;
	// Least times round up to whole cycles
	localparam int ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC     = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W      = 4;

	// Flash bus widths
	localparam int FA_W       = 19;
	localparam int FD_W       = 8;

	// Status bit positions in the flash status byte
	localparam int BIT_ACT    = 6;
	localparam int BIT_FAIL   = 5;
	localparam int BIT_WIN    = 3;

	// Read/reset command byte
	localparam logic [7:0] RESET_CMD = 8'hF0;

	// Software register map (byte addresses)
	localparam int AXI_AW     = 5;
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_ADDR   = 5'h04;
	localparam logic [4:0] OFS_WDATA  = 5'h08;
	localparam logic [4:0] OFS_STATUS = 5'h0C;
	localparam logic [4:0] OFS_RDATA  = 5'h10;

	// Status register bit positions
	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_FAIL    = 2;
	localparam int ST_LOST    = 3;
	localparam int ST_REFUSED = 4;
	localparam int ST_SUPPLY  = 5;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Commands written to the control register, bits [1:0]
	typedef enum logic [1:0] {
		CMD_READ,
		CMD_WRITE,
		CMD_POLL,
		CMD_SADD
	} cmd_t;

endpackage : flash_host_pkg

// File: rtl/strobe_cycle.sv
`timescale 1ns/10ps
module strobe_cycle (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic                          en,
	input  wire logic                          start,
	input  wire logic                          wr,
	input  wire logic [flash_host_pkg::FA_W-1:0] addr_in,
	input  wire logic [flash_host_pkg::FD_W-1:0] wdata_in,
	output logic                               done,
	output logic [flash_host_pkg::FD_W-1:0]    rdata,
	output logic [flash_host_pkg::FA_W-1:0]    fl_addr,
	output logic                               fl_ce_n,
	output logic                               fl_oe_n,
	output logic                               fl_we_n,
	input  wire logic [flash_host_pkg::FD_W-1:0] fl_dq_i,
	output logic [flash_host_pkg::FD_W-1:0]    fl_dq_o,
	output logic                               fl_dq_oe
);
	import flash_host_pkg::*;

	typedef enum logic [1:0] {E_IDLE, E_SET, E_STB, E_HLD} eng_t;

	eng_t              st_q, st_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic              wr_q, wr_d;
	logic              ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
	logic              oe_q, oe_d, done_q, done_d;
	logic [FA_W-1:0]   addr_q, addr_d;
	logic [FD_W-1:0]   dq_q, dq_d, rd_q, rd_d;

	// One bus cycle: address setup, strobe, release
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		wr_d   = wr_q;
		ce_n_d = ce_n_q;
		oe_n_d = oe_n_q;
		we_n_d = we_n_q;
		oe_d   = oe_q;
		done_d = 1'b0;
		addr_d = addr_q;
		dq_d   = dq_q;
		rd_d   = rd_q;
		unique case (st_q)
			E_IDLE: begin
				if (start) begin
					addr_d = addr_in;
					dq_d   = wdata_in;
					wr_d   = wr;
					oe_d   = wr;
					st_d   = E_SET;
				end
			end
			E_SET: begin
				// Write only with select low and output enable high
				ce_n_d = 1'b0;
				we_n_d = ~wr_q;
				oe_n_d = wr_q;
				cnt_d  = wr_q ? CNT_W'(WP_CYC - 1) : CNT_W'(ACC_CYC - 1);
				st_d   = E_STB;
			end
			E_STB: begin
				if (cnt_q == '0) begin
					// Rising write strobe latches the byte
					we_n_d = 1'b1;
					oe_n_d = 1'b1;
					if (!wr_q)
						rd_d = fl_dq_i;
					st_d = E_HLD;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			E_HLD: begin
				// Data held past the strobe edge for hold time
				ce_n_d = 1'b1;
				oe_d   = 1'b0;
				done_d = 1'b1;
				st_d   = E_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q   <= E_IDLE;
			cnt_q  <= '0;
			wr_q   <= 1'b0;
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			oe_q   <= 1'b0;
			done_q <= 1'b0;
			addr_q <= '0;
			dq_q   <= '0;
			rd_q   <= '0;
		end else if (en) begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			wr_q   <= wr_d;
			ce_n_q <= ce_n_d;
			oe_n_q <= oe_n_d;
			we_n_q <= we_n_d;
			oe_q   <= oe_d;
			done_q <= done_d;
			addr_q <= addr_d;
			dq_q   <= dq_d;
			rd_q   <= rd_d;
		end
	end

	assign done     = done_q;
	assign rdata    = rd_q;
	assign fl_addr  = addr_q;
	assign fl_ce_n  = ce_n_q;
	assign fl_oe_n  = oe_n_q;
	assign fl_we_n  = we_n_q;
	assign fl_dq_o  = dq_q;
	assign fl_dq_oe = oe_q;

	chk_write_strobes: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!fl_we_n |-> (!fl_ce_n && fl_oe_n && fl_dq_oe))
		else $error("write strobe low without select or with oe low");

endmodule : strobe_cycle

// File: rtl/flash_host.sv
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module flash_host (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic                          en,
	input  wire logic                          supply_low,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [flash_host_pkg::AXI_AW-1:0] awaddr,
	input  wire logic                          wvalid,
	output logic                               wready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	output logic                               bvalid,
	input  wire logic                          bready,
	output logic [1:0]                         bresp,
	input  wire logic                          arvalid,
	output logic                               arready,
	input  wire logic [flash_host_pkg::AXI_AW-1:0] araddr,
	output logic                               rvalid,
	input  wire logic                          rready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic [flash_host_pkg::FA_W-1:0]    fl_addr,
	output logic                               fl_ce_n,
	output logic                               fl_oe_n,
	output logic                               fl_we_n,
	input  wire logic [flash_host_pkg::FD_W-1:0] fl_dq_i,
	output logic [flash_host_pkg::FD_W-1:0]    fl_dq_o,
	output logic                               fl_dq_oe
);
	import flash_host_pkg::*;

	typedef enum logic [2:0] {
		Q_IDLE, Q_RD_A, Q_RD_B, Q_RD_C, Q_RD_D, Q_WR, Q_RST
	} seq_t;

	function automatic logic mapped(input logic [AXI_AW-1:0] a);
		mapped = (a == OFS_CTRL) || (a == OFS_ADDR) || (a == OFS_WDATA) ||
			(a == OFS_STATUS) || (a == OFS_RDATA);
	endfunction : mapped

	// Bus side state
	logic              awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
	logic [AXI_AW-1:0] awa_q, awa_d;
	logic [31:0]       wd_q, wd_d, rd_q, rd_d;
	logic [1:0]        br_q, br_d, rr_q, rr_d;
	logic [FA_W-1:0]   addr_q, addr_d;
	logic [FD_W-1:0]   wbyte_q, wbyte_d;
	logic              start;
	cmd_t              start_cmd;
	// Sequencer state
	seq_t              st_q, st_d;
	cmd_t              cmd_q, cmd_d;
	logic              iss_q, iss_d;
	logic [FD_W-1:0]   r1_q, r1_d, res_q, res_d;
	logic              done_q, done_d, fail_q, fail_d;
	logic              lost_q, lost_d, ref_q, ref_d;
	// Engine handshake
	logic              go, go_wr, eng_done;
	logic [FD_W-1:0]   go_data, eng_rdata;
	logic              aw_have, w_have, do_wr;
	logic [AXI_AW-1:0] wa;
	logic [31:0]       wv, status;

	assign status = {26'h0, supply_low, ref_q, lost_q, fail_q, done_q,
		(st_q != Q_IDLE)};

	// Address and data accepted in either order; response after both.
	// Handshakes held off while the enable freezes the registers,
	// otherwise a master would see a transfer that never lands.
	assign awready = en && !awh_q && !bv_q;
	assign wready  = en && !wh_q && !bv_q;
	assign arready = en && !rv_q;
	assign aw_have = awh_q || (awvalid && awready);
	assign w_have  = wh_q || (wvalid && wready);
	assign do_wr   = aw_have && w_have && !bv_q;
	assign wa      = awh_q ? awa_q : awaddr;
	assign wv      = wh_q ? wd_q : wdata;
	// Registers frozen while a command runs so cycles see stable values
	assign start     = do_wr && (wa == OFS_CTRL) && (st_q == Q_IDLE) && wstrb[0];
	assign start_cmd = cmd_t'(wv[1:0]);

	always_comb begin
		awh_d   = awh_q;
		wh_d    = wh_q;
		awa_d   = awa_q;
		wd_d    = wd_q;
		bv_d    = bv_q;
		br_d    = br_q;
		rv_d    = rv_q;
		rd_d    = rd_q;
		rr_d    = rr_q;
		addr_d  = addr_q;
		wbyte_d = wbyte_q;
		if (awvalid && awready) begin
			awh_d = 1'b1;
			awa_d = awaddr;
		end
		if (wvalid && wready) begin
			wh_d = 1'b1;
			wd_d = wdata;
		end
		if (bv_q && bready)
			bv_d = 1'b0;
		if (do_wr) begin
			awh_d = 1'b0;
			wh_d  = 1'b0;
			bv_d  = 1'b1;
			br_d  = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
			if (st_q == Q_IDLE && wa == OFS_ADDR)
				addr_d = wv[FA_W-1:0];
			if (st_q == Q_IDLE && wa == OFS_WDATA && wstrb[0])
				wbyte_d = wv[FD_W-1:0];
		end
		if (rv_q && rready)
			rv_d = 1'b0;
		if (arvalid && arready) begin
			rv_d = 1'b1;
			rr_d = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (araddr)
				OFS_CTRL:   rd_d = {30'h0, cmd_q};
				OFS_ADDR:   rd_d = {13'h0, addr_q};
				OFS_WDATA:  rd_d = {24'h0, wbyte_q};
				OFS_STATUS: rd_d = status;
				OFS_RDATA:  rd_d = {24'h0, res_q};
				default:    rd_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awh_q   <= 1'b0;
			wh_q    <= 1'b0;
			awa_q   <= '0;
			wd_q    <= 32'h0;
			bv_q    <= 1'b0;
			br_q    <= RESP_OKAY;
			rv_q    <= 1'b0;
			rd_q    <= 32'h0;
			rr_q    <= RESP_OKAY;
			addr_q  <= '0;
			wbyte_q <= 8'h00;
		end else if (en) begin
			awh_q   <= awh_d;
			wh_q    <= wh_d;
			awa_q   <= awa_d;
			wd_q    <= wd_d;
			bv_q    <= bv_d;
			br_q    <= br_d;
			rv_q    <= rv_d;
			rd_q    <= rd_d;
			rr_q    <= rr_d;
			addr_q  <= addr_d;
			wbyte_q <= wbyte_d;
		end
	end

	assign bvalid = bv_q && en;
	assign bresp  = br_q;
	assign rvalid = rv_q && en;
	assign rdata  = rd_q;
	assign rresp  = rr_q;

	// Sequencer: each state but Q_IDLE issues one bus cycle and acts on its result
	always_comb begin
		st_d   = st_q;
		cmd_d  = cmd_q;
		iss_d  = iss_q;
		r1_d   = r1_q;
		res_d  = res_q;
		done_d = done_q;
		fail_d = fail_q;
		lost_d = lost_q;
		ref_d  = ref_q;
		go     = 1'b0;
		if (st_q == Q_IDLE) begin
			if (start) begin
				done_d = 1'b0;
				fail_d = 1'b0;
				lost_d = 1'b0;
				cmd_d  = start_cmd;
				// No writes reach a flash from a command started in supply lockout
				ref_d  = supply_low;
				if (supply_low)
					done_d = 1'b1;
				else if (start_cmd == CMD_WRITE)
					st_d = Q_WR;
				else
					st_d = Q_RD_A;
			end
		end else if (!iss_q) begin
			go    = 1'b1;
			iss_d = 1'b1;
		end else if (eng_done) begin
			iss_d = 1'b0;
			unique case (st_q)
				Q_RD_A: begin
					r1_d = eng_rdata;
					if (cmd_q == CMD_READ) begin
						res_d = eng_rdata;
						st_d  = Q_IDLE;
					end else if (cmd_q == CMD_SADD && eng_rdata[BIT_WIN]) begin
						// Window closed already: cycle would be lost
						lost_d = 1'b1;
						st_d   = Q_IDLE;
					end else if (cmd_q == CMD_SADD) begin
						st_d = Q_WR;
					end else begin
						st_d = Q_RD_B;
					end
				end
				Q_WR: st_d = (cmd_q == CMD_SADD) ? Q_RD_B : Q_IDLE;
				Q_RD_B: begin
					res_d = eng_rdata;
					if (cmd_q == CMD_SADD) begin
						lost_d = eng_rdata[BIT_WIN];
						st_d   = Q_IDLE;
					end else if (eng_rdata[BIT_ACT] == r1_q[BIT_ACT]) begin
						st_d = Q_IDLE;
					end else if (eng_rdata[BIT_FAIL]) begin
						// Failure bit only trusted while still toggling
						st_d = Q_RD_C;
					end else begin
						r1_d = eng_rdata;
					end
				end
				Q_RD_C: begin
					r1_d = eng_rdata;
					st_d = Q_RD_D;
				end
				Q_RD_D: begin
					res_d = eng_rdata;
					if (eng_rdata[BIT_ACT] == r1_q[BIT_ACT]) begin
						st_d = Q_IDLE;
					end else begin
						fail_d = 1'b1;
						st_d   = Q_RST;
					end
				end
				Q_RST: st_d = Q_IDLE; // Back in read mode
				default: st_d = Q_IDLE;
			endcase
			if (st_d == Q_IDLE)
				done_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q   <= Q_IDLE;
			cmd_q  <= CMD_READ;
			iss_q  <= 1'b0;
			r1_q   <= 8'h00;
			res_q  <= 8'h00;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			lost_q <= 1'b0;
			ref_q  <= 1'b0;
		end else if (en) begin
			st_q   <= st_d;
			cmd_q  <= cmd_d;
			iss_q  <= iss_d;
			r1_q   <= r1_d;
			res_q  <= res_d;
			done_q <= done_d;
			fail_q <= fail_d;
			lost_q <= lost_d;
			ref_q  <= ref_d;
		end
	end

	// Reset command issued after failure
	assign go_wr   = (st_q == Q_WR) || (st_q == Q_RST);
	assign go_data = (st_q == Q_RST) ? RESET_CMD : wbyte_q;

	strobe_cycle u_cycle (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.en       (en),
		.start    (go),
		.wr       (go_wr),
		.addr_in  (addr_q),
		.wdata_in (go_data),
		.done     (eng_done),
		.rdata    (eng_rdata),
		.fl_addr  (fl_addr),
		.fl_ce_n  (fl_ce_n),
		.fl_oe_n  (fl_oe_n),
		.fl_we_n  (fl_we_n),
		.fl_dq_i  (fl_dq_i),
		.fl_dq_o  (fl_dq_o),
		.fl_dq_oe (fl_dq_oe)
	);

	chk_fail_then_reset: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(en && $rose(fail_q)) |-> (st_q == Q_RST))
		else $error("failure not followed by reset command");

	chk_fail_qualified: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(en && $rose(fail_q)) |-> ($past(st_q) == Q_RD_D))
		else $error("failure flagged outside toggle recheck");

	chk_lockout_refuse: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(en && start && supply_low) |=> (st_q == Q_IDLE && ref_q))
		else $error("command started under supply lockout");

	chk_window_lost: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(en && st_q == Q_RD_B && cmd_q == CMD_SADD && eng_done && iss_q)
		|=> (lost_q == $past(eng_rdata[BIT_WIN]) && st_q == Q_IDLE))
		else $error("window recheck result not reported");

	cov_poll_ok: cover property (@(posedge aclk) disable iff (!aresetn)
		st_q == Q_RD_B ##1 st_q == Q_IDLE);
	cov_poll_fail: cover property (@(posedge aclk) disable iff (!aresetn)
		$rose(fail_q));
	cov_sadd_lost: cover property (@(posedge aclk) disable iff (!aresetn)
		$rose(lost_q));

endmodule : flash_host

// File: testbench/flash_model.sv
`timescale 1ns/10ps
module flash_model #(
	parameter int         PROG_N  = 3,
	parameter int         WIN_N   = 2,
	parameter int         ERASE_N = 4,
	parameter logic [7:0] PROT    = 8'h80
) (
	input  wire logic [flash_host_pkg::FA_W-1:0] fl_addr,
	input  wire logic                            fl_ce_n,
	input  wire logic                            fl_oe_n,
	input  wire logic                            fl_we_n,
	input  wire logic [flash_host_pkg::FD_W-1:0] fl_dq_o,
	input  wire logic                            fl_dq_oe,
	input  wire logic                            lockout,
	output logic      [flash_host_pkg::FD_W-1:0] dq
);
	import flash_host_pkg::*;
	localparam logic [7:0] PGM_CODE = 8'hA0;
	localparam logic [7:0] ERS_CODE = 8'h30;
	localparam logic [7:0] CHP_CODE = 8'hC5; // Arbitrary code for this model
	logic [7:0] mem [128];
	logic [7:0] st;
	logic [7:0] last_q;
	logic [7:0] pdat_q;
	logic [7:0] marked_q;
	logic       armed_q, fail_q, t6_q, t2_q;
	int         pcnt_q, win_q, ecnt_q;
	wire  [6:0] ix   = {fl_addr[18:16], fl_addr[3:0]};
	wire  [2:0] sec  = fl_addr[18:16];
	wire        rd   = !fl_ce_n && !fl_oe_n;
	wire        wr   = !fl_ce_n && !fl_we_n && fl_oe_n;
	wire        prog = pcnt_q > 0 || fail_q;
	wire        ers  = win_q > 0 || ecnt_q > 0;

	// Power-up lands in read-array mode with a blank array
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		{last_q, pdat_q, marked_q} = '0;
		{armed_q, fail_q, t6_q, t2_q} = '0;
		{pcnt_q, win_q, ecnt_q} = '0;
	end

	// Status byte replaces array data at any address while busy
	always_comb begin
		st = mem[ix];
		if (prog)
			st = {~pdat_q[7], t6_q, fail_q, 5'h00};
		else if (ers)
			st = {1'b0, t6_q, 2'b00, win_q == 0,
				marked_q[sec] & t2_q, 2'b00};
	end

	// Released bus shows the inverse, so a stale byte never passes
	assign dq = fl_dq_oe ? fl_dq_o : (rd ? st : ~last_q);

	// Toggle flops flip at the end of each read cycle while busy, t2_q only for a marked sector during erase
	always @(negedge rd) begin
		last_q = st;
		if (prog || ers) t6_q = ~t6_q;
		if (ers && marked_q[sec]) t2_q = ~t2_q;
		if (pcnt_q > 0) pcnt_q--;
		if (win_q > 0) win_q--;
		else if (ecnt_q > 0) begin
			ecnt_q--;
			if (ecnt_q == 0) begin
				foreach (mem[i]) if (marked_q[i / 16]) mem[i] = 8'hFF;
				marked_q = '0;
			end
		end
	end

	// Writes land on the strobe edge that ends the cycle
	always @(negedge wr) begin
		last_q = fl_dq_o;
		if (lockout) begin
			{armed_q, fail_q, marked_q} = '0;
			{pcnt_q, win_q, ecnt_q} = '0;
		end else if (!(ers && win_q == 0)) begin
			if (fl_dq_o == RESET_CMD) begin
				{armed_q, fail_q, marked_q} = '0;
				{pcnt_q, win_q, ecnt_q} = '0;
			end else if (armed_q) begin
				armed_q = 1'b0;
				pdat_q = fl_dq_o;
				pcnt_q = PROG_N;
				if (!PROT[sec] && |(fl_dq_o & ~mem[ix])) fail_q = 1'b1;
				else if (!PROT[sec]) mem[ix] = fl_dq_o;
			end else if (fl_dq_o == PGM_CODE) begin
				armed_q = 1'b1;
			end else if (fl_dq_o == ERS_CODE) begin
				marked_q[sec] = marked_q[sec] | ~PROT[sec];
				win_q = WIN_N;
				if (ecnt_q == 0) ecnt_q = ERASE_N;
			end else if (fl_dq_o == CHP_CODE) begin
				marked_q = ~PROT;
				win_q = 0;
				ecnt_q = ERASE_N;
			end
		end
	end
endmodule : flash_model

// File: testbench/tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
	n_errors++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); \
	end end
module tb;
	import flash_host_pkg::*;
	localparam logic [31:0] S_DONE = 32'h1 << ST_DONE;
	localparam logic [31:0] S_FAIL = 32'h1 << ST_FAIL;
	localparam logic [31:0] S_LOST = 32'h1 << ST_LOST;
	localparam logic [31:0] S_REF  = 32'h1 << ST_REFUSED;
	localparam logic [31:0] S_SUP  = 32'h1 << ST_SUPPLY;
	logic            aclk, aresetn, en, supply_low;
	logic            awvalid, awready, wvalid, wready, bvalid, bready;
	logic            arvalid, arready, rvalid, rready;
	logic [4:0]      awaddr, araddr;
	logic [31:0]     wdata, rdata, st, rword;
	logic [3:0]      wstrb;
	logic [1:0]      bresp, rresp, resp;
	logic [FA_W-1:0] fl_addr;
	logic            fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
	logic [FD_W-1:0] fl_dq_i, fl_dq_o;
	int              n_errors, n_checks;

	flash_host flash_host_inst (
		.aclk(aclk), .aresetn(aresetn), .en(en), .supply_low(supply_low),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
		.fl_we_n(fl_we_n), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o),
		.fl_dq_oe(fl_dq_oe)
	);
	flash_model flash_model_inst (
		.fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
		.fl_we_n(fl_we_n), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
		.lockout(supply_low), .dq(fl_dq_i)
	);

	// Free-running 50 MHz clock
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// Address and data offered together, each dropped once taken
	task automatic axw(input logic [4:0] a, input logic [31:0] d);
		bit ad = 0;
		bit dd = 0;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awaddr <= a;
		wdata <= d;
		do begin
			@(posedge aclk);
			if (!ad && awready) begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (!dd && wready) begin
				dd = 1;
				wvalid <= 1'b0;
			end
		end while (!(ad && dd));
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [4:0] a);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rword = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axr

	// One flash command, then status polled until the engine idles
	task automatic run(input cmd_t c, input logic [18:0] a,
		input logic [7:0] d);
		axw(OFS_ADDR, {13'h0000, a});
		axw(OFS_WDATA, {24'h000000, d});
		axw(OFS_CTRL, {30'h00000000, c});
		do axr(OFS_STATUS); while (rword[ST_BUSY] !== 1'b0);
		st = rword;
	endtask : run

	task automatic rdb(input logic [18:0] a, input logic [7:0] e);
		run(CMD_READ, a, 8'h00);
		axr(OFS_RDATA);
		`CHK(rword, {24'h000000, e})
	endtask : rdb

	task automatic print_verdict;
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// Whole sequence needs a few thousand cycles at most
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		print_verdict();
	end

	initial begin
		{aresetn, supply_low, awvalid, wvalid, bready} = '0;
		{arvalid, rready, awaddr, araddr, wdata} = '0;
		{n_errors, n_checks} = '0;
		en = 1'b1;
		wstrb = 4'hF;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		axr(OFS_STATUS);
		`CHK(rword, 32'h00000000)
		axr(5'h14);
		`CHK(resp, RESP_SLVERR)
		axw(5'h14, 32'h00000001);
		`CHK(resp, RESP_SLVERR)
		axw(OFS_ADDR, 32'h00040000);
		`CHK(resp, RESP_OKAY)
		axr(OFS_ADDR);
		`CHK(rword, 32'h00040000)
		run(CMD_READ, 19'h00010, 8'h00);
		`CHK(st, S_DONE)
		rdb(19'h00010, 8'hFF);
		// Program a byte and poll until the activity bit settles
		run(CMD_WRITE, 19'h00010, 8'hA0);
		run(CMD_WRITE, 19'h00010, 8'h5A);
		run(CMD_POLL, 19'h00010, 8'h00);
		`CHK(st, S_DONE)
		rdb(19'h00010, 8'h5A);
		// One over zero: the device fails and must be reset
		run(CMD_WRITE, 19'h00010, 8'hA0);
		run(CMD_WRITE, 19'h00010, 8'hFF);
		run(CMD_POLL, 19'h00010, 8'h00);
		`CHK(st, S_DONE | S_FAIL)
		rdb(19'h00010, 8'h5A);
		// Erase, one sector added in the window and one too late
		run(CMD_WRITE, 19'h00010, 8'h30);
		run(CMD_SADD, 19'h40000, 8'h30);
		`CHK(st, S_DONE)
		run(CMD_READ, 19'h40000, 8'h00);
		run(CMD_SADD, 19'h50000, 8'h30);
		`CHK(st, S_DONE | S_LOST)
		run(CMD_POLL, 19'h40000, 8'h00);
		`CHK(st, S_DONE)
		rdb(19'h00010, 8'hFF);
		// Chip erase has no sector-add window: a late sector is lost
		run(CMD_WRITE, 19'h00010, 8'hC5);
		run(CMD_SADD, 19'h10000, 8'h30);
		`CHK(st, S_DONE | S_LOST)
		run(CMD_POLL, 19'h10000, 8'h00);
		`CHK(st, S_DONE)
		// Low supply refuses the command without a flash cycle
		supply_low <= 1'b1;
		run(CMD_WRITE, 19'h00010, 8'h00);
		`CHK(st, S_DONE | S_REF | S_SUP)
		supply_low <= 1'b0;
		rdb(19'h00010, 8'hFF);
		// Enable low mid-command freezes bus and flash cycle alike
		fork
			rdb(19'h40000, 8'hFF);
			begin
				repeat (14) @(posedge aclk);
				en <= 1'b0;
				repeat (6) @(posedge aclk);
				en <= 1'b1;
			end
		join
		print_verdict();
	end
endmodule : tb
